// *** rtl/rrc_defines.svh ***
/*
 * Register offsets, field positions, reset values and timing counts
 * for the radio receive/transmit control block.
 * Assumes a 40 MHz system clock and an AHB-Lite register bus.
 */
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH

// Printed register indices; byte address is four times the index
`define RRC_IDX_STATE_CMD 8'h02
`define RRC_IDX_OUTPUT_POWER_LEVEL 8'h05
`define RRC_IDX_CTRL_TWO 8'h0c
`define RRC_IDX_RECEIVE_THRESHOLD_LEVEL 8'h15
`define RRC_IDX_STATUS 8'h20
`define RRC_IDX_RSSI_FLOOR 8'h21
// Byte addresses
`define RRC_ADDR_STATE_CMD 12'h008
`define RRC_ADDR_OUTPUT_POWER_LEVEL 12'h014
`define RRC_ADDR_CTRL_TWO 12'h030
`define RRC_ADDR_RECEIVE_THRESHOLD_LEVEL 12'h054
`define RRC_ADDR_STATUS 12'h080
`define RRC_ADDR_RSSI_FLOOR 12'h084

// Command codes of the transceiver command field
`define RRC_CMD_NOP 5'h00
`define RRC_CMD_TX_START 5'h02
`define RRC_CMD_TRANSCEIVER_IDLE_STATE 5'h08
`define RRC_CMD_PLL_ON 5'h09
`define RRC_CMD_RX_ON 5'h06
`define RRC_CMD_AACK_ON 5'h16
`define RRC_CMD_ARET_ON 5'h19

// Reset values
`define RRC_OUTPUT_POWER_LEVEL_RST 8'hc0
`define RRC_RECEIVE_THRESHOLD_LEVEL_RST 8'h00
`define RRC_CTRL_TWO_RST 8'h00
`define RRC_RSSI_FLOOR_RST 8'ha5

// Field positions
`define RRC_SYNC_DIS_BIT 7
`define RRC_SAFE_MODE_BIT 7
`define RRC_RECEIVE_THRESHOLD_LEVEL_MASK 8'h8f

// Timing
`define RRC_CLK_MHZ 40
`define RRC_MOD_START_US 16
`define RRC_MOD_START_CYC (`RRC_MOD_START_US * `RRC_CLK_MHZ)
`define RRC_LT_STEP_US 2
`define RRC_LT_STEP_CYC (`RRC_LT_STEP_US * `RRC_CLK_MHZ)

`endif

// *** rtl/rrc_pkg.sv ***
/*
 * Types for the radio receive/transmit control block.
 * Assumes nothing of its surroundings.
 */
package rrc_pkg;
  typedef enum logic [2:0] {
    RRC_OFF,
    RRC_PLL_ON,
    RRC_RX_ON,
    RRC_RX_BUSY,
    RRC_AACK_ON,
    RRC_ARET_ON,
    RRC_TX_BUSY
  } rrc_state_t;
endpackage : rrc_pkg

// *** rtl/rrc_ctrl.sv ***
/*
 * Digital receive/transmit control of a packet radio: state commands,
 * sync-detect gating, frame buffer protection, LQI append and transmit
 * amplifier ramping, with an AHB-Lite register slave.
 * Assumes a baseband front end that supplies sync, header, end-of-frame,
 * RSSI, correlation and FCS indications synchronous to clk_sys_in.
 */
`timescale 1ns/10ps
`include "rrc_defines.svh"
module rrc_ctrl (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Control pins
  input wire logic sleep_transmit_pin_in,
  input wire logic spi_sel_b_in,
  input wire logic ext_mode_in,
  // Baseband receive indications and transmit done
  input wire logic shr_detect_in,
  input wire logic phr_valid_in,
  input wire logic rx_octet_valid_in,
  input wire logic [7:0] rx_octet_in,
  input wire logic rx_done_in,
  input wire logic fcs_valid_in,
  input wire logic [7:0] rssi_in,
  input wire logic [7:0] corr_quality_in,
  input wire logic [7:0] freq_est_in,
  input wire logic tx_done_in,
  // Outputs
  output rrc_pkg::rrc_state_t state_out,
  output logic rx_start_irq_out,
  output logic frame_end_irq_out,
  output logic buf_we_out,
  output logic [7:0] buf_wdata_out,
  output logic [7:0] freq_corr_out,
  output logic demod_en_out,
  output logic amp_buffer_en_out,
  output logic amp_en_out,
  output logic modulate_out,
  output logic fe_tx_switch_out,
  output logic [3:0] output_power_level_out
);
  import rrc_pkg::*;

  localparam int MOD_CYC = `RRC_MOD_START_CYC;
  localparam int STEP_CYC = `RRC_LT_STEP_CYC;

  rrc_state_t state;
  logic [7:0] tx_power_control;
  logic [7:0] receiver_threshold_control;
  logic [7:0] transceiver_control_two;
  logic [7:0] rssi_floor_value;
  logic [7:0] lqi_acc;
  logic pin_q;
  logic prot_hold;
  logic sel_q;
  logic [9:0] tx_cnt;
  logic ap_valid;
  logic ap_write;
  logic [11:0] ap_addr;

  // Address phase decode
  wire ap_take = hsel_in & hready_in & htrans_in[1];
  wire dp_write = ap_valid & ap_write;
  wire wr_cmd = dp_write & (ap_addr == `RRC_ADDR_STATE_CMD);
  wire wr_pwr = dp_write & (ap_addr == `RRC_ADDR_OUTPUT_POWER_LEVEL);
  wire wr_ctl2 = dp_write & (ap_addr == `RRC_ADDR_CTRL_TWO);
  wire wr_thr = dp_write & (ap_addr == `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL);
  wire wr_floor = dp_write & (ap_addr == `RRC_ADDR_RSSI_FLOOR);
  wire [4:0] transceiver_command_field = wr_cmd ? hwdata_in[4:0] : `RRC_CMD_NOP;

  // Fields
  wire [1:0] amp_buffer_lead_time = tx_power_control[7:6];
  wire [1:0] amp_lead_time = tx_power_control[5:4];
  wire sync_detect_disable = receiver_threshold_control[`RRC_SYNC_DIS_BIT];
  wire [3:0] sync_detect_threshold = receiver_threshold_control[3:0];
  wire safe_mode = transceiver_control_two[`RRC_SAFE_MODE_BIT];

  wire [9:0] receive_threshold_level = 10'(rssi_floor_value) + 10'(3) * (10'(sync_detect_threshold) - 10'd1);
  wire rssi_ok = (sync_detect_threshold == 4'h0) || (10'(rssi_in) > receive_threshold_level);

  wire in_listen = (state == RRC_RX_ON) || (state == RRC_AACK_ON);
  wire sync_ok = shr_detect_in & phr_valid_in & rssi_ok & ~sync_detect_disable;
  wire frame_start = in_listen & sync_ok & ~prot_hold;
  wire can_rx = (state == RRC_OFF) || (state == RRC_PLL_ON);
  // trigger by pin edge or command
  wire tx_trig = ((state == RRC_PLL_ON) || (state == RRC_ARET_ON)) &
                 ((sleep_transmit_pin_in & ~pin_q) || (transceiver_command_field == `RRC_CMD_TX_START));
  wire [9:0] pa_lead = 10'(STEP_CYC) * (10'(amp_lead_time) + 10'd1);
  wire [9:0] buf_lead = pa_lead + 10'(STEP_CYC) * 10'(amp_buffer_lead_time);
  // Cycles left before modulation; held at zero so the ramp stays on while modulating
  wire [9:0] to_mod = (tx_cnt >= 10'(MOD_CYC - 1)) ? 10'h000 : 10'(MOD_CYC - 1) - tx_cnt;
  wire busy_tx = state == RRC_TX_BUSY;

  rrc_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      RRC_OFF, RRC_PLL_ON: begin
        if (can_rx && transceiver_command_field == `RRC_CMD_RX_ON)
          next_state = RRC_RX_ON;
        else if (can_rx && ext_mode_in && transceiver_command_field == `RRC_CMD_AACK_ON)
          next_state = RRC_AACK_ON;
        else if (transceiver_command_field == `RRC_CMD_ARET_ON && ext_mode_in)
          next_state = RRC_ARET_ON;
        else if (transceiver_command_field == `RRC_CMD_PLL_ON)
          next_state = RRC_PLL_ON;
        else if (transceiver_command_field == `RRC_CMD_TRANSCEIVER_IDLE_STATE)
          next_state = RRC_OFF;
        else if (tx_trig)
          next_state = RRC_TX_BUSY;
      end
      RRC_RX_ON, RRC_AACK_ON: begin
        if (frame_start)
          next_state = RRC_RX_BUSY;
        else if (!prot_hold && transceiver_command_field == `RRC_CMD_PLL_ON)
          next_state = RRC_PLL_ON;
        else if (!prot_hold && transceiver_command_field == `RRC_CMD_TRANSCEIVER_IDLE_STATE)
          next_state = RRC_OFF;
      end
      RRC_RX_BUSY: begin
        if (rx_done_in)
          next_state = ext_mode_in ? RRC_AACK_ON : RRC_RX_ON;
      end
      RRC_ARET_ON: begin
        if (tx_trig)
          next_state = RRC_TX_BUSY;
        else if (transceiver_command_field == `RRC_CMD_PLL_ON)
          next_state = RRC_PLL_ON;
      end
      RRC_TX_BUSY: begin
        if (tx_done_in)
          next_state = RRC_PLL_ON;
      end
    endcase
  end

  // Next values of registered outputs
  // buffer no later than amplifier
  wire next_buf_en = busy_tx & (to_mod <= buf_lead);
  wire next_pa_en = busy_tx & (to_mod <= pa_lead);
  wire next_mod = busy_tx & (to_mod == 10'h000);
  wire rx_end = (state == RRC_RX_BUSY) & rx_done_in;
  wire [7:0] next_lqi = rx_octet_valid_in ? ((lqi_acc >> 1) + (corr_quality_in >> 1)) : lqi_acc;

  // Register read mux, looked up at the address phase
  wire [11:0] rd_addr = {haddr_in[11:2], 2'b00};
  wire rd_rw = (rd_addr == `RRC_ADDR_OUTPUT_POWER_LEVEL) | (rd_addr == `RRC_ADDR_CTRL_TWO) |
               (rd_addr == `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL) | (rd_addr == `RRC_ADDR_RSSI_FLOOR);
  // A write landing in this cycle is forwarded so a back-to-back read sees it;
  // state and status still show the value from before that write
  wire fwd = dp_write & rd_rw & (ap_addr == rd_addr);
  wire [7:0] fwd_byte = (rd_addr == `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL) ?
                        (hwdata_in[7:0] & `RRC_RECEIVE_THRESHOLD_LEVEL_MASK) : hwdata_in[7:0];
  wire [7:0] reg_byte =
    (rd_addr == `RRC_ADDR_STATE_CMD) ? {3'h0, 2'(state), 3'h0} :
    (rd_addr == `RRC_ADDR_OUTPUT_POWER_LEVEL) ? tx_power_control :
    (rd_addr == `RRC_ADDR_CTRL_TWO) ? transceiver_control_two :
    (rd_addr == `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL) ? receiver_threshold_control :
    (rd_addr == `RRC_ADDR_STATUS) ? {4'h0, prot_hold, 3'(state)} :
    (rd_addr == `RRC_ADDR_RSSI_FLOOR) ? rssi_floor_value : 8'h00;
  wire [7:0] rd_byte = fwd ? fwd_byte : reg_byte;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state <= RRC_OFF;
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
      hrdata_out <= 32'h0000_0000;
      tx_power_control <= `RRC_OUTPUT_POWER_LEVEL_RST;
      receiver_threshold_control <= `RRC_RECEIVE_THRESHOLD_LEVEL_RST;
      transceiver_control_two <= `RRC_CTRL_TWO_RST;
      rssi_floor_value <= `RRC_RSSI_FLOOR_RST;
    end else begin
      state <= next_state;
      ap_valid <= ap_take;
      ap_write <= hwrite_in;
      ap_addr <= {haddr_in[11:2], 2'b00};
      // Read data launched at the address phase, standing through the data phase
      if (ap_take && !hwrite_in)
        hrdata_out <= {24'h000000, rd_byte};
      if (wr_pwr)
        tx_power_control <= hwdata_in[7:0];
      if (wr_thr)
        receiver_threshold_control <= hwdata_in[7:0] & `RRC_RECEIVE_THRESHOLD_LEVEL_MASK;
      if (wr_ctl2)
        transceiver_control_two <= hwdata_in[7:0];
      if (wr_floor)
        rssi_floor_value <= hwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pin_q <= 1'b0;
      sel_q <= 1'b1;
      prot_hold <= 1'b0;
      tx_cnt <= 10'h000;
      lqi_acc <= 8'h00;
      freq_corr_out <= 8'h00;
    end else begin
      pin_q <= sleep_transmit_pin_in;
      sel_q <= spi_sel_b_in;
      tx_cnt <= busy_tx ? ((tx_cnt == 10'h3ff) ? tx_cnt : tx_cnt + 10'h001) : 10'h000;
      if (rx_end && safe_mode && fcs_valid_in)
        prot_hold <= 1'b1;
      else if (spi_sel_b_in && !sel_q)
        prot_hold <= 1'b0;
      if (frame_start)
        freq_corr_out <= freq_est_in;
      lqi_acc <= frame_start ? 8'hff : next_lqi;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_out <= RRC_OFF;
      rx_start_irq_out <= 1'b0;
      frame_end_irq_out <= 1'b0;
      buf_we_out <= 1'b0;
      buf_wdata_out <= 8'h00;
      demod_en_out <= 1'b0;
      amp_buffer_en_out <= 1'b0;
      amp_en_out <= 1'b0;
      modulate_out <= 1'b0;
      fe_tx_switch_out <= 1'b0;
      output_power_level_out <= 4'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      state_out <= next_state;
      rx_start_irq_out <= frame_start & ~ext_mode_in;
      frame_end_irq_out <= rx_end & ~ext_mode_in;
      buf_we_out <= (state == RRC_RX_BUSY) & (rx_octet_valid_in | rx_done_in);
      buf_wdata_out <= rx_done_in ? lqi_acc : rx_octet_in;
      demod_en_out <= (next_state == RRC_RX_BUSY);
      amp_buffer_en_out <= next_buf_en;
      amp_en_out <= next_pa_en;
      modulate_out <= next_mod;
      fe_tx_switch_out <= next_buf_en;
      output_power_level_out <= tx_power_control[3:0];
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
endmodule : rrc_ctrl

// *** verification/rrc_ctrl_monitor.sv ***
/* Port checker for rrc_ctrl: bus answer, state entries, tx ramp, irq pulses.
   Bound to every rrc_ctrl instance; sees its ports only. */
`timescale 1ns/10ps
module rrc_ctrl_monitor (
  // Clock, reset, mode
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ext_mode_in,
  // Observed outputs
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire rrc_pkg::rrc_state_t state_out,
  input wire logic rx_start_irq_out,
  input wire logic frame_end_irq_out,
  input wire logic amp_buffer_en_out,
  input wire logic amp_en_out,
  input wire logic modulate_out,
  input wire logic fe_tx_switch_out,
  input wire logic demod_en_out
);
  import rrc_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_enter(rrc_state_t s);
    $changed(state_out) && state_out == s;
  endsequence
  property p_bus_ok; hreadyout_out && !hresp_out; endproperty
  property p_rx_src; s_enter(RRC_RX_ON) |-> $past(state_out) inside {RRC_OFF, RRC_PLL_ON, RRC_RX_BUSY}; endproperty
  property p_aack_src; s_enter(RRC_AACK_ON) |-> $past(state_out) inside {RRC_OFF, RRC_PLL_ON, RRC_RX_BUSY}; endproperty
  property p_tx_src; s_enter(RRC_TX_BUSY) |-> $past(state_out) inside {RRC_PLL_ON, RRC_ARET_ON}; endproperty
  property p_tx_quiet; s_enter(RRC_TX_BUSY) |-> !modulate_out [*8]; endproperty
  property p_amp_seq; amp_en_out |-> amp_buffer_en_out; endproperty
  property p_amp_lead; $rose(modulate_out) |-> $past(amp_en_out, 8); endproperty
  property p_irq_basic; (rx_start_irq_out || frame_end_irq_out) |-> !ext_mode_in; endproperty
  property p_start_pulse; rx_start_irq_out |=> !rx_start_irq_out; endproperty
  property p_end_pulse; frame_end_irq_out |=> !frame_end_irq_out; endproperty
  property p_fe_switch; fe_tx_switch_out == amp_buffer_en_out; endproperty
  property p_demod; demod_en_out == (state_out == RRC_RX_BUSY); endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  a_rx_src: assert property (p_rx_src) else $error("receive on entered from wrong state");
  a_aack_src: assert property (p_aack_src) else $error("auto ack entered from wrong state");
  a_tx_src: assert property (p_tx_src) else $error("transmit entered from wrong state");
  a_tx_quiet: assert property (p_tx_quiet) else $error("modulation began too early");
  a_amp_seq: assert property (p_amp_seq) else $error("amplifier on without buffer");
  a_amp_lead: assert property (p_amp_lead) else $error("amplifier lead too short");
  a_irq_basic: assert property (p_irq_basic) else $error("receive irq in extended mode");
  a_start_pulse: assert property (p_start_pulse) else $error("start irq longer than a cycle");
  a_end_pulse: assert property (p_end_pulse) else $error("end irq longer than a cycle");
  a_fe_switch: assert property (p_fe_switch) else $error("front end switch off buffer timing");
  a_demod: assert property (p_demod) else $error("demodulation enable off receive state");
endmodule : rrc_ctrl_monitor
bind rrc_ctrl rrc_ctrl_monitor u_rrc_ctrl_monitor (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .ext_mode_in(ext_mode_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .state_out(state_out),
  .rx_start_irq_out(rx_start_irq_out), .frame_end_irq_out(frame_end_irq_out),
  .amp_buffer_en_out(amp_buffer_en_out), .amp_en_out(amp_en_out), .modulate_out(modulate_out),
  .fe_tx_switch_out(fe_tx_switch_out), .demod_en_out(demod_en_out));

// *** verification/rrc_bb_model.sv ***
/* Baseband receive model: one frame per go pulse.
   Assumes go only while idle; lines churn outside frames. */
`timescale 1ns/10ps
module rrc_bb_model (
  // Control
  input wire logic clk_sys_in,
  input wire logic go_in,
  input wire logic [7:0] rssi_set_in,
  input wire logic fcs_ok_in,
  // Frame indications
  output logic shr_out,
  output logic phr_out,
  output logic oct_v_out,
  output logic [7:0] oct_out,
  output logic done_out,
  output logic fcs_out,
  output logic [7:0] rssi_out,
  output logic [7:0] corr_out,
  output logic [7:0] freq_out
);
  logic [3:0] step = 4'h0;
  // Header from step 1, three octets, end pulse at step 6
  always @(posedge clk_sys_in) begin
    if (go_in && step == 4'h0) step <= 4'h1;
    else if (step != 4'h0) step <= (step == 4'h7) ? 4'h0 : step + 4'h1;
  end
  assign shr_out = step >= 4'h1 && step <= 4'h6;
  assign phr_out = shr_out;
  assign oct_v_out = step >= 4'h3 && step <= 4'h5;
  assign oct_out = oct_v_out ? {4'ha, step} : ~{4'ha, step};
  assign done_out = step == 4'h6;
  assign fcs_out = done_out ? fcs_ok_in : step[0];
  assign rssi_out = rssi_set_in;
  assign corr_out = 8'hc8;
  assign freq_out = shr_out ? 8'h11 : {4'h0, step};
endmodule : rrc_bb_model

// *** verification/rrc_ctrl_tb_top.sv ***
/* Testbench for rrc_ctrl: AHB-Lite register tasks, receive and transmit.
   Assumes zero wait states and a 40 MHz clock. */
`timescale 1ns/10ps
`include "rrc_defines.svh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, a); end end
module rrc_ctrl_tb_top;
  import rrc_pkg::*;
  logic clk_sys_in = 0, rst_b_in = 0, hsel = 0, hwrite = 0, pin = 0, go = 0, tx_done = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, prv = 0;
  logic [31:0] hwdata = 0, rd, hrdata;
  logic [7:0] rssi_set = 8'hff, oct, rssi, corr, freq;
  logic sel_b = 1, ext = 0, fcs_ok = 1, pin_prv = 0;
  logic [7:0] wdat, fcorr, wd_last = 8'h00;
  int t_dp = 0;
  logic [7:0] tv [8] = '{8'h8f, 8'h02, 8'h02, 8'h01, 8'h01, 8'h0f, 8'h0f, 8'h00};
  logic [7:0] rv [8] = '{8'hff, 8'ha8, 8'ha9, 8'ha5, 8'ha6, 8'hcf, 8'hd0, 8'h00};
  int ev [8] = '{0, 0, 1, 0, 1, 0, 1, 1};
  logic hready, hresp, shr, phr, ov, done, fcs, rs, fe, we, abuf, amp, md;
  logic [3:0] pwr;
  rrc_state_t st;
  int fails = 0, n_compared = 0, cyc = 0, n_rs = 0, n_fe = 0, n_we = 0, a, b, c, t_buf, t_amp, t_mod, t_pin;
  rrc_bb_model u_rrc_bb_model (.clk_sys_in(clk_sys_in), .go_in(go), .rssi_set_in(rssi_set), .shr_out(shr),
    .phr_out(phr), .oct_v_out(ov), .oct_out(oct), .done_out(done), .fcs_out(fcs), .rssi_out(rssi),
    .corr_out(corr), .freq_out(freq), .fcs_ok_in(fcs_ok));
  rrc_ctrl u_rrc_ctrl (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .sleep_transmit_pin_in(pin),
    .spi_sel_b_in(sel_b), .ext_mode_in(ext), .shr_detect_in(shr), .phr_valid_in(phr), .rx_octet_valid_in(ov),
    .rx_octet_in(oct), .rx_done_in(done), .fcs_valid_in(fcs), .rssi_in(rssi), .corr_quality_in(corr),
    .freq_est_in(freq), .tx_done_in(tx_done), .state_out(st), .rx_start_irq_out(rs), .frame_end_irq_out(fe),
    .buf_we_out(we), .buf_wdata_out(wdat), .freq_corr_out(fcorr), .demod_en_out(), .amp_buffer_en_out(abuf),
    .amp_en_out(amp), .modulate_out(md), .fe_tx_switch_out(), .output_power_level_out(pwr));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    prv <= {abuf, amp, md};
    pin_prv <= pin;
    if (pin && !pin_prv) t_pin = cyc;
    if (we) wd_last = wdat;
    if (rs) n_rs++;
    if (fe) n_fe++;
    if (we) n_we++;
    if (abuf && !prv[2]) t_buf = cyc;
    if (amp && !prv[1]) t_amp = cyc;
    if (md && !prv[0]) t_mod = cyc;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task finish_test();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task ahb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk_sys_in);
    hsel <= 1; htrans <= 2'b10; haddr <= ad; hwrite <= wr; hsize <= 3'b010;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rd = hrdata;
    t_dp = cyc;
    hsel <= 0;
    // One more edge so registered outputs reflect the write
    @(posedge clk_sys_in);
    #1;
  endtask : ahb
  task frame(input logic [7:0] r);
    a = n_rs; b = n_fe; c = n_we;
    @(posedge clk_sys_in);
    rssi_set <= r; go <= 1;
    @(posedge clk_sys_in);
    go <= 0;
    repeat (12) @(posedge clk_sys_in);
  endtask : frame
  task tx_check(input int lead_buf, input int lead_amp);
    repeat (700) @(posedge clk_sys_in);
    `CHK("tx_state", RRC_TX_BUSY, st)
    `CHK("buf_lead", lead_buf, t_amp - t_buf)
    `CHK("amp_lead", lead_amp, t_mod - t_amp)
    // The rise is first seen one edge after the output changes
    `CHK("mod_delay", `RRC_MOD_START_CYC + 1, t_mod - t_pin)
    tx_done <= 1;
    @(posedge clk_sys_in);
    tx_done <= 0; pin <= 0;
  endtask : tx_check
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1;
    ahb(0, `RRC_ADDR_OUTPUT_POWER_LEVEL, 0); `CHK("pwr_rst", 32'hc0, rd)
    ahb(0, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, 0); `CHK("thr_rst", 32'h0, rd)
    ahb(1, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, 32'hff); ahb(0, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, 0); `CHK("thr_rsv", 32'h8f, rd)
    ahb(0, 12'h0fc, 0); `CHK("unmapped", 32'h0, rd)
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_RX_ON); `CHK("rx_on", RRC_RX_ON, st)
    // Sync disable, then threshold edges either side
    for (int i = 0; i < 8; i++) begin
      ahb(1, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, {24'h0, tv[i]});
      frame(rv[i]);
      `CHK("rx_start", ev[i], n_rs - a)
      `CHK("rx_end", ev[i], n_fe - b)
      `CHK("lqi_app", 4 * ev[i], n_we - c)
    end
    `CHK("lqi_val", 8'hce, wd_last)
    `CHK("freq_corr", 8'h11, fcorr)
    // Disable set mid-frame spares that frame
    fork
      frame(8'hff);
      begin
        repeat (3) @(posedge clk_sys_in);
        ahb(1, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, 32'h80);
      end
    join
    `CHK("mid_dis", 1, n_fe - b)
    // Clearing the disable receives again; safe mode guards FCS-valid frames only
    ahb(1, `RRC_ADDR_RECEIVE_THRESHOLD_LEVEL, 0);
    ahb(1, `RRC_ADDR_CTRL_TWO, 32'h80);
    fcs_ok <= 0;
    frame(8'hff);
    `CHK("dis_clr", 1, n_rs - a)
    frame(8'hff);
    `CHK("bad_fcs", 1, n_rs - a)
    fcs_ok <= 1;
    frame(8'hff);
    `CHK("good_fcs", 1, n_rs - a)
    frame(8'hff);
    `CHK("guarded", 0, n_rs - a)
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_PLL_ON);
    `CHK("held_rx", RRC_RX_ON, st)
    sel_b <= 0;
    fcs_ok <= 0;
    @(posedge clk_sys_in);
    sel_b <= 1;
    frame(8'hff);
    `CHK("released", 1, n_rs - a)
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_PLL_ON); `CHK("pll_on", RRC_PLL_ON, st)
    @(posedge clk_sys_in);
    pin <= 1;
    tx_check(240, 80);
    ahb(1, `RRC_ADDR_OUTPUT_POWER_LEVEL, 32'h15); `CHK("pwr_lvl", 4'h5, pwr)
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_TX_START);
    t_pin = t_dp;
    tx_check(0, 160);
    // Extended mode: auto-ack receive stores frames without basic-mode irqs
    ext <= 1;
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_AACK_ON);
    `CHK("aack_on", RRC_AACK_ON, st)
    frame(8'hff);
    `CHK("ext_irq", 0, n_rs - a + n_fe - b)
    `CHK("ext_store", 4, n_we - c)
    ahb(1, `RRC_ADDR_STATE_CMD, `RRC_CMD_RX_ON);
    `CHK("rx_refused", RRC_AACK_ON, st)
    finish_test();
  end
endmodule : rrc_ctrl_tb_top
